// ===== logic/phy_dev_end.sv
/*
  Transceiver end of the host interface: MII and RMII pin logic, the
  loopback path, strap capture and output release around reset.
  Assumes all link pins arrive asynchronously to sys_clk and that the
  line side presents nibbles on rx_nib_in when rx_take asks for them.
*/
`timescale 1ns/1ps
`include "phy_map.svh"
module phy_dev_end (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  phy_link_if.dev                lnk,
  input  wire phy_pkg::phy_nib_t rx_nib_in,
  input  wire logic              rx_dv_in,
  input  wire logic              rx_er_in,
  input  wire logic              carrier_in,
  input  wire logic              loop_en,
  input  wire logic              link_100fd,
  output phy_pkg::phy_nib_t      tx_nib,
  output logic                   tx_nib_vld,
  output logic                   tx_er_out,
  output logic                   rx_take,
  output logic                   mode_rmii,
  output logic                   speed100
);
  import phy_pkg::*;

  localparam int LAST = `PHY_LOOP_EDGES - 1;

  logic [9:0] sy1_reg;
  logic [9:0] sy2_reg;
  logic       hrst_n;
  logic       s_ref;
  phy_nib_t   s_txd;
  logic       s_txen;
  logic       s_txer;
  phy_dst_t   dst_reg;
  logic [7:0] ocnt_reg;
  logic       oe_reg;
  logic       run;
  logic       ref_prev_reg;
  logic       ref_rise;
  logic [5:0] mcnt_reg;
  logic       mclk_reg;
  logic [5:0] half;
  logic       mii_on;
  logic       mrise;
  logic       loop;
  logic [5:0] lp_reg [`PHY_LOOP_EDGES];
  logic [5:0] src;
  phy_nib_t   rxd_reg;
  logic       rxdv_reg;
  logic       rxer_reg;
  logic       crs_reg;
  logic       rph_reg;
  phy_dib_t   rhi_reg;
  logic       tph_reg;
  phy_dib_t   tlo_reg;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= 10'h000;
      sy2_reg <= 10'h000;
    end else begin
      sy1_reg <= {lnk.hw_reset_n, lnk.ref_clock_in, lnk.h_txd,
                  lnk.h_txen, lnk.h_txer, lnk.strap_rmii, lnk.strap_100};
      sy2_reg <= sy1_reg;
    end
  end

  assign hrst_n = sy2_reg[9];
  assign s_ref  = sy2_reg[8];
  assign s_txd  = sy2_reg[7:4];
  assign s_txen = sy2_reg[3];
  assign s_txer = sy2_reg[2];

  // ************************************************************
  // Hardware reset, straps and output release
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dst_reg  <= DR_RST;
      ocnt_reg <= 8'h00;
    end else if (!hrst_n) begin
      dst_reg  <= DR_RST;
      ocnt_reg <= 8'h00;
    end else begin
      case (dst_reg)
        DR_RST: begin
          dst_reg <= DR_WAIT;
        end
        DR_WAIT: begin
          if (ocnt_reg == 8'(`PHY_ODAD_CYC - `PHY_ODAD_SLACK)) begin
            dst_reg <= DR_RUN;
          end else begin
            ocnt_reg <= ocnt_reg + 8'h01;
          end
        end
        DR_RUN: begin
          dst_reg <= DR_RUN;
        end
        default: begin
          dst_reg <= DR_RST;
        end
      endcase
    end
  end

  // strap capture
  // The pulled levels are taken on the first synchronised cycle after
  // release, which keeps the asynchronous reset branch constant.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_rmii <= 1'b0;
      speed100  <= 1'b0;
    end else if (dst_reg == DR_RST && hrst_n) begin
      mode_rmii <= sy2_reg[1];
      speed100  <= sy2_reg[0];
    end
  end

  // fast release
  // Reset reaches the enable after three edges, far inside the bound.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (dst_reg == DR_RUN) & hrst_n;
    end
  end

  assign run = (dst_reg == DR_RUN);

  // ************************************************************
  // MII clock divider
  // ************************************************************
  assign mii_on = run & ~mode_rmii;
  assign half   = speed100 ? 6'(`PHY_MII100_HALF) : 6'(`PHY_MII10_HALF);
  assign mrise  = mii_on & ~mclk_reg & (mcnt_reg == half - 6'h01);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mcnt_reg <= 6'h00;
      mclk_reg <= 1'b0;
    end else if (!mii_on) begin
      mcnt_reg <= 6'h00;
      mclk_reg <= 1'b0;
    end else if (mcnt_reg == half - 6'h01) begin
      mcnt_reg <= 6'h00;
      mclk_reg <= ~mclk_reg;
    end else begin
      mcnt_reg <= mcnt_reg + 6'h01;
    end
  end

  // ************************************************************
  // Reference clock edge finder
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= s_ref;
    end
  end

  assign ref_rise = run & mode_rmii & s_ref & ~ref_prev_reg;

  // ************************************************************
  // Loopback delay line
  // ************************************************************
  assign loop = loop_en & link_100fd & speed100;

  // loopback latency
  // One stage per transmit clock rise gives exactly four periods.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i <= LAST; i++) begin
        lp_reg[i] <= 6'h00;
      end
    end else if (mrise) begin
      lp_reg[0] <= {s_txer, s_txen, s_txd};
      for (int i = 1; i <= LAST; i++) begin
        lp_reg[i] <= lp_reg[i-1];
      end
    end
  end

  assign src = loop ? lp_reg[LAST] : {rx_er_in, rx_dv_in, rx_nib_in};

  // ************************************************************
  // Transmit capture
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_nib     <= 4'h0;
      tx_nib_vld <= 1'b0;
      tx_er_out  <= 1'b0;
      tph_reg    <= 1'b0;
      tlo_reg    <= 2'h0;
    end else begin
      tx_nib_vld <= 1'b0;
      if (!run) begin
        tph_reg <= 1'b0;
      end else if (mrise) begin
        tx_nib     <= s_txd;
        tx_nib_vld <= s_txen;
        tx_er_out  <= s_txer;
      end else if (ref_rise) begin
        // Low di-bit first; the pair is handed on as one nibble.
        if (tph_reg) begin
          tx_nib     <= {s_txd[1:0], tlo_reg};
          tx_nib_vld <= 1'b1;
          tph_reg    <= 1'b0;
        end else if (s_txen) begin
          tlo_reg <= s_txd[1:0];
          tph_reg <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Receive launch
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_reg  <= 4'h0;
      rxdv_reg <= 1'b0;
      rxer_reg <= 1'b0;
      rx_take  <= 1'b0;
      rph_reg  <= 1'b0;
      rhi_reg  <= 2'h0;
    end else begin
      rx_take <= 1'b0;
      if (!run) begin
        rxd_reg  <= 4'h0;
        rxdv_reg <= 1'b0;
        rxer_reg <= 1'b0;
        rph_reg  <= 1'b0;
      end else if (mrise) begin
        rxd_reg  <= src[3:0];
        rxdv_reg <= src[4];
        rxer_reg <= src[5];
        rx_take  <= ~loop & rx_dv_in;
      end else if (ref_rise) begin
        if (rph_reg) begin
          rxd_reg <= {2'h0, rhi_reg};
          rph_reg <= 1'b0;
        end else if (rx_dv_in) begin
          rxd_reg  <= {2'h0, rx_nib_in[1:0]};
          rhi_reg  <= rx_nib_in[3:2];
          rxer_reg <= rx_er_in;
          rx_take  <= 1'b1;
          rph_reg  <= 1'b1;
        end else begin
          rxd_reg  <= 4'h0;
          rxer_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Carrier sense and data valid
  // ************************************************************
  // unaligned assert
  // tail toggling
  // Carrier raises the flag on any system cycle; once carrier is gone
  // the flag follows the di-bit phase on each reference rise.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      crs_reg <= 1'b0;
    end else if (!run || !mode_rmii) begin
      crs_reg <= 1'b0;
    end else if (carrier_in) begin
      crs_reg <= 1'b1;
    end else if (ref_rise) begin
      crs_reg <= rph_reg;
    end
  end

  assign lnk.dv_txclk = mclk_reg;
  assign lnk.dv_rxclk = mclk_reg;
  assign lnk.dv_rxd   = rxd_reg;
  assign lnk.dv_rxdv  = rxdv_reg;
  assign lnk.dv_rxer  = rxer_reg;
  assign lnk.dv_crs   = crs_reg;
  assign lnk.dv_oe    = oe_reg;
endmodule

// ===== logic/phy_link_if.sv
/*
  Pin bundle between the transceiver end and the controller end.
  Assumes undriven transceiver pins and straps settle to the pull level.
*/
`timescale 1ns/1ps
interface phy_link_if;
  logic       dv_txclk;
  logic       dv_rxclk;
  logic [3:0] dv_rxd;
  logic       dv_rxdv;
  logic       dv_rxer;
  logic       dv_crs;
  logic       dv_oe;
  logic [3:0] h_txd;
  logic       h_txen;
  logic       h_txer;
  logic       ref_clock_in;
  logic       hw_reset_n;
  logic       h_pu_rmii;
  logic       h_pu_100;
  logic       strap_rmii;
  logic       strap_100;
  logic       txclk;
  logic       rxclk;
  logic [3:0] rxd;
  logic       rxdv;
  logic       rxer;
  logic       crs_dv;

  // Released transceiver pins fall to the weak pull-down level.
  assign txclk      = dv_oe & dv_txclk;
  assign rxclk      = dv_oe & dv_rxclk;
  assign rxd        = dv_oe ? dv_rxd : 4'h0;
  assign rxdv       = dv_oe & dv_rxdv;
  assign rxer       = dv_oe & dv_rxer;
  assign crs_dv     = dv_oe & dv_crs;
  assign strap_rmii = h_pu_rmii;
  assign strap_100  = h_pu_100;

  modport dev (
    input  h_txd, h_txen, h_txer, ref_clock_in, hw_reset_n,
    input  strap_rmii, strap_100,
    output dv_txclk, dv_rxclk, dv_rxd, dv_rxdv, dv_rxer, dv_crs, dv_oe
  );
  modport mac (
    output h_txd, h_txen, h_txer, ref_clock_in, hw_reset_n,
    output h_pu_rmii, h_pu_100,
    input  txclk, rxclk, rxd, rxdv, rxer, crs_dv
  );
endinterface

// ===== logic/phy_mac_end.sv
/*
  Controller end of the host interface: reset sequencing, strap pulls,
  reference clock, and nibble transfer in either MII or RMII.
  Assumes transceiver pins arrive asynchronously to sys_clk.
*/
`timescale 1ns/1ps
`include "phy_map.svh"
module phy_mac_end #(
  parameter int unsigned PURSTD_CYC   = `PHY_PURSTD_CYC,
  parameter int unsigned RST_HOLD_CYC = `PHY_RST_HOLD_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  phy_link_if.mac                lnk,
  input  wire logic              cfg_rmii,
  input  wire logic              cfg_100,
  input  wire logic              reset_req,
  input  wire phy_pkg::phy_nib_t tx_nib_in,
  input  wire logic              tx_en_in,
  input  wire logic              tx_er_in,
  output logic                   tx_take,
  output phy_pkg::phy_nib_t      rx_nib,
  output logic                   rx_vld,
  output logic                   rx_er
);
  import phy_pkg::*;

  logic [8:0]  sy1_reg;
  logic [8:0]  sy2_reg;
  phy_hst_t    hst_reg;
  logic [22:0] rc_reg;
  logic        rstn_reg;
  logic [2:0]  rcnt_reg;
  logic [2:0]  rnext;
  logic        ref_reg;
  logic        r_fall;
  logic        r_smp;
  logic        tclk_prev_reg;
  logic        rclk_prev_reg;
  phy_nib_t    txd_reg;
  logic        txen_reg;
  logic        txer_reg;
  logic        tph_reg;
  phy_dib_t    thi_reg;
  logic        infr_reg;
  logic        rph_reg;
  logic        crs0_reg;
  phy_dib_t    rlo_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= 9'h000;
      sy2_reg <= 9'h000;
    end else begin
      sy1_reg <= {lnk.txclk, lnk.rxclk, lnk.rxd, lnk.rxdv, lnk.rxer,
                  lnk.crs_dv};
      sy2_reg <= sy1_reg;
    end
  end

  // ************************************************************
  // Hardware reset sequencer
  // ************************************************************
  // minimum hold
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hst_reg  <= HR_PWR;
      rc_reg   <= 23'h000000;
      rstn_reg <= 1'b0;
    end else begin
      rstn_reg <= (hst_reg == HR_RUN) & ~reset_req;
      case (hst_reg)
        HR_PWR: begin
          if (rc_reg == 23'(PURSTD_CYC - 1)) begin
            hst_reg <= HR_HOLD;
            rc_reg  <= 23'h000000;
          end else begin
            rc_reg <= rc_reg + 23'h000001;
          end
        end
        HR_HOLD: begin
          if (rc_reg == 23'(RST_HOLD_CYC - 1)) begin
            hst_reg <= HR_RUN;
            rc_reg  <= 23'h000000;
          end else begin
            rc_reg <= rc_reg + 23'h000001;
          end
        end
        HR_RUN: begin
          if (reset_req) begin
            hst_reg <= HR_HOLD;
          end
        end
        default: begin
          hst_reg <= HR_PWR;
        end
      endcase
    end
  end

  // ************************************************************
  // Reference clock divider
  // ************************************************************
  assign rnext  = (rcnt_reg == 3'(`PHY_RMII_DIV - 1)) ? 3'h0
                                                      : rcnt_reg + 3'h1;
  assign r_fall = cfg_rmii & (rcnt_reg == 3'(`PHY_RMII_HI - 1));
  assign r_smp  = cfg_rmii & (rcnt_reg == 3'(`PHY_RMII_SMP));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt_reg <= 3'h0;
      ref_reg  <= 1'b0;
    end else if (!cfg_rmii) begin
      rcnt_reg <= 3'h0;
      ref_reg  <= 1'b0;
    end else begin
      rcnt_reg <= rnext;
      ref_reg  <= (rnext < 3'(`PHY_RMII_HI));
    end
  end

  // ************************************************************
  // Transmit drive
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tclk_prev_reg <= 1'b0;
      txd_reg       <= 4'h0;
      txen_reg      <= 1'b0;
      txer_reg      <= 1'b0;
      tx_take       <= 1'b0;
      tph_reg       <= 1'b0;
      thi_reg       <= 2'h0;
    end else begin
      tclk_prev_reg <= sy2_reg[8];
      tx_take       <= 1'b0;
      if (!cfg_rmii && !tclk_prev_reg && sy2_reg[8]) begin
        txd_reg  <= tx_nib_in;
        txen_reg <= tx_en_in;
        txer_reg <= tx_er_in;
        tx_take  <= tx_en_in;
      end else if (r_fall) begin
        if (tph_reg) begin
          txd_reg <= {2'h0, thi_reg};
          tph_reg <= 1'b0;
        end else begin
          txd_reg  <= {2'h0, tx_nib_in[1:0]};
          thi_reg  <= tx_nib_in[3:2];
          txen_reg <= tx_en_in;
          tx_take  <= tx_en_in;
          tph_reg  <= tx_en_in;
        end
      end
    end
  end

  // ************************************************************
  // Receive capture
  // ************************************************************
  // A nibble ends the frame only when carrier is low on both di-bits,
  // since the flag toggles while the last bits drain.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rclk_prev_reg <= 1'b0;
      rx_nib        <= 4'h0;
      rx_vld        <= 1'b0;
      rx_er         <= 1'b0;
      infr_reg      <= 1'b0;
      rph_reg       <= 1'b0;
      crs0_reg      <= 1'b0;
      rlo_reg       <= 2'h0;
    end else begin
      rclk_prev_reg <= sy2_reg[7];
      rx_vld        <= 1'b0;
      if (!cfg_rmii && !rclk_prev_reg && sy2_reg[7]) begin
        rx_nib <= sy2_reg[6:3];
        rx_vld <= sy2_reg[2];
        rx_er  <= sy2_reg[1];
      end else if (r_smp) begin
        if (!infr_reg) begin
          if (sy2_reg[0] && sy2_reg[4:3] != 2'h0) begin
            infr_reg <= 1'b1;
            rph_reg  <= 1'b1;
            crs0_reg <= 1'b1;
            rlo_reg  <= sy2_reg[4:3];
          end
        end else if (!rph_reg) begin
          rph_reg  <= 1'b1;
          crs0_reg <= sy2_reg[0];
          rlo_reg  <= sy2_reg[4:3];
        end else begin
          rph_reg <= 1'b0;
          if (crs0_reg || sy2_reg[0]) begin
            rx_nib <= {sy2_reg[4:3], rlo_reg};
            rx_vld <= 1'b1;
            rx_er  <= sy2_reg[1];
          end else begin
            infr_reg <= 1'b0;
          end
        end
      end
    end
  end

  // pull-only straps
  // The strap nets only see which pull is fitted; nothing enables a
  // driver onto them.
  assign lnk.h_pu_rmii    = cfg_rmii;
  assign lnk.h_pu_100     = cfg_100;
  assign lnk.hw_reset_n   = rstn_reg;
  assign lnk.ref_clock_in = ref_reg;
  assign lnk.h_txd        = txd_reg;
  assign lnk.h_txen       = txen_reg;
  assign lnk.h_txer       = txer_reg;
endmodule

// ===== logic/phy_map.svh
/*
  Constants for the transceiver host interface: clock periods, reset
  timing and the cycle counts derived from them.
  Assumes a 250 MHz system clock at both ends of the link.
*/
// Contract
// - MII clocks: 40 ns fast, 400 ns slow
// - MII transmit pins sampled on clock rise
// - MII receive pins launched on clock rise
// - Loopback receive valid 160 to 162 ns
// - RMII carrier asserted unaligned to reference
// - Tail carrier toggles: high on second di-bit
// - Controller gives reference clock, period 20+ ns
// - RMII receive di-bit launched per reference rise
// - Reset held low at least 100 us
// - Reset released 25 ms after power, monotonic
// - Straps captured by the hardware reset
// - Tri-state fast; drive again within 800 ns
// - Straps only pulled, never actively driven
`ifndef PHY_MAP_SVH
`define PHY_MAP_SVH

`define PHY_SYS_T_NS     4
`define PHY_MII100_T_NS  40
`define PHY_MII10_T_NS   400
`define PHY_MII100_HALF  ((`PHY_MII100_T_NS / `PHY_SYS_T_NS) / 2)
`define PHY_MII10_HALF   ((`PHY_MII10_T_NS / `PHY_SYS_T_NS) / 2)
`define PHY_LOOP_T_NS    160
`define PHY_LOOP_EDGES   (`PHY_LOOP_T_NS / `PHY_MII100_T_NS)
`define PHY_ODAD_CLKS    20
`define PHY_ODAD_MHZ     25
`define PHY_ODAD_CYC     ((`PHY_ODAD_CLKS * 1000 / `PHY_ODAD_MHZ) / `PHY_SYS_T_NS)
`define PHY_ODAD_SLACK   8
`define PHY_RMII_T_NS    20
`define PHY_RMII_DIV     ((`PHY_RMII_T_NS + `PHY_SYS_T_NS - 1) / `PHY_SYS_T_NS)
`define PHY_RMII_HI      2
`define PHY_RMII_SMP     2
`define PHY_RST_HOLD_US  100
`define PHY_RST_HOLD_CYC ((`PHY_RST_HOLD_US * 1000 + `PHY_SYS_T_NS - 1) / `PHY_SYS_T_NS)
`define PHY_PURSTD_MS    25
`define PHY_PURSTD_CYC   ((`PHY_PURSTD_MS * 1000000 + `PHY_SYS_T_NS - 1) / `PHY_SYS_T_NS)

`endif

// ===== logic/phy_pkg.sv
/*
  Types shared by both ends of the transceiver host interface.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package phy_pkg;
  typedef logic [3:0] phy_nib_t;
  typedef logic [1:0] phy_dib_t;
  typedef enum logic [2:0] {
    DR_RST  = 3'h1,
    DR_WAIT = 3'h2,
    DR_RUN  = 3'h4
  } phy_dst_t;
  typedef enum logic [2:0] {
    HR_PWR  = 3'h1,
    HR_HOLD = 3'h2,
    HR_RUN  = 3'h4
  } phy_hst_t;
endpackage

// ===== verification/phy_link_checker.sv
/*
  Checker for the pins between the two ends of the link.
  Assumes one sys_clk domain and straps read while reset is held.
*/
`timescale 1ns/1ps
module phy_link_checker #(
  parameter int unsigned PURSTD_CYC   = 50,
  parameter int unsigned RST_HOLD_CYC = 20
) (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       hw_reset_n,
  input wire logic       dv_oe,
  input wire logic       txclk,
  input wire logic       rxclk,
  input wire logic [3:0] rxd,
  input wire logic       ref_clock_in,
  input wire logic       strap_rmii,
  input wire logic       strap_100
);
  int unsigned low_cnt;
  int unsigned up_cnt;
  logic        rmii_m;
  logic        f100_m;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ********************
  // Helper state.
  // ********************
  // The mode follows the straps only while reset is held.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rmii_m <= 1'h0;
      f100_m <= 1'h0;
    end else if (!hw_reset_n) begin
      rmii_m <= strap_rmii;
      f100_m <= strap_100;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= '0;
      up_cnt  <= '0;
    end else begin
      low_cnt <= hw_reset_n ? '0 : low_cnt + 1;
      up_cnt  <= (up_cnt < PURSTD_CYC) ? up_cnt + 1 : up_cnt;
    end
  end

  sequence s_tx_next;
    ##1 (!$rose(txclk))[*8] ##1 !$rose(txclk) ##1 ($rose(txclk) || !dv_oe);
  endsequence
  sequence s_ref_next;
    ##1 (!$rose(ref_clock_in))[*4] ##1 ($rose(ref_clock_in) || !hw_reset_n);
  endsequence

  chk_oe_release: assert property (
    $fell(hw_reset_n) |-> ##[1:12] !dv_oe)
    else $error("pins still driven in reset");
  chk_oe_drive: assert property (
    $rose(hw_reset_n) |-> ##[1:200] dv_oe)
    else $error("pins not driven after reset");
  chk_rst_hold: assert property (
    $rose(hw_reset_n) |-> low_cnt >= RST_HOLD_CYC)
    else $error("reset pulse too short");
  chk_power_wait: assert property (
    $rose(hw_reset_n) |-> up_cnt >= PURSTD_CYC)
    else $error("reset released too early");
  chk_mii_fast: assert property (
    !rmii_m && f100_m && $past(dv_oe) && $rose(txclk) |-> s_tx_next)
    else $error("fast clock period wrong");
  chk_mii_slow: assert property (
    !rmii_m && !f100_m && $past(dv_oe) && $rose(txclk)
    |-> ##100 ($rose(txclk) || !dv_oe))
    else $error("slow clock period wrong");
  chk_rx_launch: assert property (
    !rmii_m && hw_reset_n && $past(dv_oe) && !$stable(rxd) |-> $rose(rxclk))
    else $error("receive nibble off the clock rise");
  chk_unused_quiet: assert property (
    rmii_m && hw_reset_n && dv_oe && $past(dv_oe)
    |-> $stable(txclk) && $stable(rxclk))
    else $error("unused clock pins toggle");
  chk_ref_period: assert property (
    rmii_m && hw_reset_n && $rose(ref_clock_in) |-> s_ref_next)
    else $error("reference period wrong");
endmodule

// ===== verification/test_phy_mii_rmii_host_interface.sv
/*
  Bench joining both ends of the link, with the link checker beside it.
  Assumes the design sources are compiled first.
*/
`timescale 1ns/1ps
module test_phy_mii_rmii_host_interface;
  import phy_pkg::*;
  logic       sys_clk    = 1'h0;
  logic       arst_n     = 1'h0;
  phy_nib_t   rx_nib_in  = 4'h0;
  phy_nib_t   tx_nib_in  = 4'h0;
  logic       rx_dv_in   = 1'h0;
  logic       rx_er_in   = 1'h0;
  logic       carrier_in = 1'h0;
  logic       loop_en    = 1'h0;
  logic       link_100fd = 1'h0;
  logic       cfg_rmii   = 1'h0;
  logic       cfg_100    = 1'h1;
  logic       reset_req  = 1'h0;
  logic       tx_en_in   = 1'h0;
  logic       tx_er_in   = 1'h0;
  phy_nib_t   tx_nib, rx_nib;
  logic       tx_nib_vld, tx_er_out, rx_take, mode_rmii, speed100;
  logic       tx_take, rx_vld, rx_er, crs_prev;
  int         err_count = 0, cmp_count = 0, cyc = 0, crs_rise = 0;
  logic [4:0] txq[$], rxq[$];
  int         txt[$];

  phy_link_if lnk_if ();
  phy_dev_end phy_dev_end_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .lnk(lnk_if.dev), .rx_nib_in(rx_nib_in), .rx_dv_in(rx_dv_in),
    .rx_er_in(rx_er_in), .carrier_in(carrier_in), .loop_en(loop_en),
    .link_100fd(link_100fd), .tx_nib(tx_nib), .tx_nib_vld(tx_nib_vld),
    .tx_er_out(tx_er_out), .rx_take(rx_take), .mode_rmii(mode_rmii),
    .speed100(speed100));
  phy_mac_end #(.PURSTD_CYC(50), .RST_HOLD_CYC(20)) phy_mac_end_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk_if.mac),
    .cfg_rmii(cfg_rmii), .cfg_100(cfg_100), .reset_req(reset_req),
    .tx_nib_in(tx_nib_in), .tx_en_in(tx_en_in), .tx_er_in(tx_er_in),
    .tx_take(tx_take), .rx_nib(rx_nib), .rx_vld(rx_vld), .rx_er(rx_er));
  phy_link_checker #(.PURSTD_CYC(50), .RST_HOLD_CYC(20)) phy_link_checker_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .hw_reset_n(lnk_if.hw_reset_n),
    .dv_oe(lnk_if.dv_oe), .txclk(lnk_if.txclk), .rxclk(lnk_if.rxclk),
    .rxd(lnk_if.rxd), .ref_clock_in(lnk_if.ref_clock_in),
    .strap_rmii(lnk_if.strap_rmii), .strap_100(lnk_if.strap_100));

  // ********************
  // Clock and collectors.
  // ********************
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    crs_prev <= lnk_if.crs_dv;
    if (lnk_if.crs_dv === 1'h1 && crs_prev === 1'h0 && carrier_in === 1'h0)
      crs_rise <= crs_rise + 1;
    if (tx_nib_vld === 1'h1) begin
      txq.push_back({tx_er_out, tx_nib});
      txt.push_back(cyc);
    end
    if (rx_vld === 1'h1)
      rxq.push_back({rx_er, rx_nib});
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic restart(logic p, logic r, logic f);
    cfg_rmii <= r;
    cfg_100 <= f;
    reset_req <= p;
    @(posedge sys_clk);
    reset_req <= 1'h0;
    // Hold time plus the 800 ns drive limit ends well inside this wait.
    repeat (300) @(posedge sys_clk);
    check("dv_oe", lnk_if.dv_oe, 1'h1);
    check("mode_rmii", mode_rmii, r);
    check("speed100", speed100, f);
    $display("restart %0d %0d done", r, f);
  endtask

  task automatic send_tx(phy_nib_t nib, logic er);
    tx_nib_in <= nib;
    tx_en_in <= 1'h1;
    tx_er_in <= er;
    @(posedge sys_clk);
    for (int i = 0; i < 300 && tx_take !== 1'h1; i++)
      @(posedge sys_clk);
  endtask

  task automatic send_rx(phy_nib_t nib, logic er);
    rx_nib_in <= nib;
    rx_dv_in <= 1'h1;
    rx_er_in <= er;
    @(posedge sys_clk);
    for (int i = 0; i < 300 && rx_take !== 1'h1; i++)
      @(posedge sys_clk);
  endtask

  // ********************
  // Scenarios.
  // ********************
  task automatic t_tx(logic f, logic mii);
    txq.delete();
    txt.delete();
    send_tx(4'h5, 1'h0);
    send_tx(4'hA, 1'h1);
    send_tx(4'hC, 1'h0);
    tx_en_in <= 1'h0;
    tx_er_in <= 1'h0;
    repeat (f ? 60 : 400) @(posedge sys_clk);
    check("tx data", {txq[0], txq[1], txq[2]}, mii ? 16'h174C : 16'h154C);
    check("tx gap", 16'(txt[2] - txt[1]), f ? 16'hA : 16'h64);
    $display("tx test %0d %0d done", f, mii);
  endtask

  task automatic t_mii_rx();
    rxq.delete();
    send_rx(4'h3, 1'h0);
    send_rx(4'hE, 1'h1);
    send_rx(4'h7, 1'h0);
    rx_dv_in <= 1'h0;
    rx_er_in <= 1'h0;
    repeat (60) @(posedge sys_clk);
    check("mii rx data", {rxq[0], rxq[1], rxq[2]}, 16'h0FC7);
    $display("mii rx test done");
  endtask

  task automatic t_loop();
    int t0;
    int t1;
    loop_en <= 1'h1;
    link_100fd <= 1'h1;
    rxq.delete();
    fork
      begin
        send_tx(4'h9, 1'h0);
        send_tx(4'h6, 1'h0);
        send_tx(4'hF, 1'h0);
        tx_en_in <= 1'h0;
      end
      begin
        for (int i = 0; i < 300 &&
             (lnk_if.h_txen !== 1'h1 || lnk_if.txclk !== 1'h0); i++)
          @(posedge sys_clk);
        for (int i = 0; i < 30 && lnk_if.txclk !== 1'h1; i++)
          @(posedge sys_clk);
        t0 = cyc;
        for (int i = 0; i < 90 && lnk_if.rxdv !== 1'h1; i++)
          @(posedge sys_clk);
        t1 = cyc;
      end
    join
    repeat (60) @(posedge sys_clk);
    check("loop delay", 16'(t1 - t0), 16'h28);
    check("loop data", {rxq[0], rxq[1], rxq[2]}, 16'h24CF);
    loop_en <= 1'h0;
    $display("loopback test done");
  endtask

  task automatic t_rmii_rx();
    int base;
    rxq.delete();
    carrier_in <= 1'h1;
    repeat (4) @(posedge sys_clk);
    check("crs_dv early", lnk_if.crs_dv, 1'h1);
    send_rx(4'h3, 1'h0);
    send_rx(4'h9, 1'h0);
    base = crs_rise;
    carrier_in <= 1'h0;
    send_rx(4'h6, 1'h0);
    rx_dv_in <= 1'h0;
    repeat (60) @(posedge sys_clk);
    check("rmii rx data", {rxq[0], rxq[1], rxq[2]}, 16'h0D26);
    check("tail toggle", 16'(crs_rise > base), 16'h1);
    $display("rmii rx test done");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    restart(1'h0, 1'h0, 1'h1);
    t_tx(1'h1, 1'h1);
    t_mii_rx();
    t_loop();
    restart(1'h1, 1'h0, 1'h0);
    t_tx(1'h0, 1'h1);
    restart(1'h1, 1'h1, 1'h1);
    t_tx(1'h1, 1'h0);
    t_rmii_rx();
    tally_and_finish();
  end

  // The tests take about 2100 cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("Error watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
